/* File: common/sme_pkg.sv */
`default_nettype none
package sme_pkg;
    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int DATA_W  = 32;
    localparam int LEN_W   = 5;
    localparam int FRAME_LENGTH_FIELD_W  = 12;
    localparam int CNT_W   = 16;
    localparam int NUM_SEL = 4;
    localparam int SEL_W   = 2;
    localparam int DD_W    = 2;
    localparam int DIV_W   = 8;
    localparam int CMD_W   = 2;
    localparam int EDGE_W  = LEN_W + 1;

    // ****************************************************************
    // Command codes and timing
    // ****************************************************************
    localparam logic [CMD_W-1:0] CMD_READ  = 2'h1;
    localparam logic [CMD_W-1:0] CMD_WRITE = 2'h2;
    // Half serial period is div+1 cycles; a two-cycle minimum keeps the ratio at four
    localparam logic [DIV_W-1:0] MIN_DIV    = 8'h01;
    localparam int               FIFO_DEPTH = 8;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [DATA_W-1:0]  RST_DATA  = 32'h0;
    localparam logic [CNT_W-1:0]   RST_COUNT = 16'h0;
    localparam logic [NUM_SEL-1:0] RST_SEL   = 4'h0;
    localparam logic               RST_FLAG  = 1'b0;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_LOAD  = 4'b0010,
        ST_LEAD  = 4'b0100,
        ST_SHIFT = 4'b1000
    } sme_state_e;
endpackage : sme_pkg
`default_nettype wire

/* File: rtl/sme_fifo.sv */
`default_nettype none
module sme_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
        $error("sme_fifo: DEPTH must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    assign in_ready  = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data  = mem_r[rd_ptr_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule : sme_fifo
`default_nettype wire

/* File: rtl/sme_clk_div.sv */
`default_nettype none
module sme_clk_div #(
    parameter int WIDTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             run,
    input  wire logic             restart,
    input  wire logic [WIDTH-1:0] div,
    output logic                  tick
);
    if (WIDTH < 1) begin : g_width_check
        $error("sme_clk_div: WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] div_eff;

    // Settings below the minimum would break the four-to-one clock ratio
    assign div_eff = (div < WIDTH'(sme_pkg::MIN_DIV)) ? WIDTH'(sme_pkg::MIN_DIV) : div;
    assign tick    = run && !restart && (cnt_r == div_eff);

    // Halted while the peripheral clock gate is off, so the engine freezes in place
    always_ff @(posedge core_clk) begin
        if (rst || restart) begin
            cnt_r <= '0;
        end else if (run) begin
            cnt_r <= (cnt_r == div_eff) ? '0 : cnt_r + 1'b1;
        end
    end
endmodule : sme_clk_div
`default_nettype wire

/* File: rtl/sme_top.sv */
`default_nettype none
// Functional notes
// - Master only; drives clock and selects
// - Character length 1 to 32 bits
// - Frame of up to 4096 characters
// - Four selects; command picks one
// - Select held active over whole frame
// - Command write starts access immediately
// - Per-select polarity: 0 low, 1 high
// - Divider keeps clock four times serial
// - Clock edges match character length exactly
// - Count adds one per character
// - Frame flag; cleared by status read/command
// - Extra lead delay 0 to 3 periods
// - Interrupt per character or per frame
// - Selectable internal loopback
// - Per-slave idle level and edge
// - Functional clock can be gated
// - Clock, selects, transmit out; receive in
// - Four modes set shift/sample edges
// - First edge waits half period plus lead
// - Left shift; in at LSB, out MSB
// - Busy during shift, clear between characters
module sme_top #(
    parameter int FIFO_W = sme_pkg::DATA_W,
    parameter int FIFO_D = sme_pkg::FIFO_DEPTH
) (
    input  wire logic                           core_clk,
    input  wire logic                           rst,
    input  wire logic                           periph_clk_run,
    input  wire logic                           cmd_wr,
    input  wire logic [sme_pkg::SEL_W-1:0]      select_number_field,
    input  wire logic [sme_pkg::LEN_W-1:0]      char_length_field,
    input  wire logic [sme_pkg::CMD_W-1:0]      cmd_code,
    input  wire logic [sme_pkg::FRAME_LENGTH_FIELD_W-1:0]     frame_length_field,
    input  wire logic [sme_pkg::DIV_W-1:0]      clk_div,
    input  wire logic [sme_pkg::NUM_SEL-1:0]    select_polarity_bit,
    input  wire logic [sme_pkg::NUM_SEL-1:0]    clock_idle_level_bit,
    input  wire logic [sme_pkg::NUM_SEL-1:0]    clock_phase_bit,
    input  wire logic [2*sme_pkg::NUM_SEL-1:0]  select_to_data_delay,
    input  wire logic                           loopback_en,
    input  wire logic                           char_irq_en,
    input  wire logic                           frame_irq_en,
    input  wire logic                           status_rd,
    input  wire logic                           tx_valid,
    output logic                                tx_ready,
    input  wire logic [FIFO_W-1:0]              tx_data,
    output logic                                rx_valid,
    output logic      [sme_pkg::DATA_W-1:0]     rx_data,
    output logic                                busy,
    output logic                                char_done_flag,
    output logic                                frame_done_flag,
    output logic      [sme_pkg::CNT_W-1:0]      char_count_field,
    output logic                                char_irq,
    output logic                                frame_irq,
    output logic                                sclk_out,
    output logic                                mosi_out,
    input  wire logic                           miso_in,
    output logic      [sme_pkg::NUM_SEL-1:0]    slave_select_out
);
    if (FIFO_W != sme_pkg::DATA_W || FIFO_D < 2) begin : g_param_check
        $error("sme_top: FIFO must be one data word wide and at least 2 deep");
    end

    // ****************************************************************
    // Declarations
    // ****************************************************************
    sme_pkg::sme_state_e             state_r;
    logic [sme_pkg::SEL_W-1:0]       sel_r;
    logic [sme_pkg::LEN_W-1:0]       len_r;
    logic [sme_pkg::CMD_W-1:0]       code_r;
    logic [sme_pkg::FRAME_LENGTH_FIELD_W-1:0]      left_r;
    logic                            first_r;
    logic [sme_pkg::EDGE_W-1:0]      edge_r;
    logic [2:0]                      lead_r;
    logic [sme_pkg::DATA_W-1:0]      shreg_r;
    logic [sme_pkg::DATA_W-1:0]      shreg_nxt;
    logic [sme_pkg::NUM_SEL-1:0]     sel_act_r;
    logic                            sclk_r;
    logic                            tx_r;
    logic                            miso_s1_r;
    logic                            miso_s2_r;
    logic                            rx_in;
    logic                            tick;
    logic                            start;
    logic                            leave_load;
    logic                            sample;
    logic                            char_end;
    logic                            frame_end;
    logic                            cpol;
    logic                            cpha;
    logic [sme_pkg::DD_W-1:0]        dd;
    logic                            fifo_out_valid;
    logic                            fifo_out_ready;
    logic [FIFO_W-1:0]               fifo_out_data;

    // ****************************************************************
    // Per-slave settings and event terms
    // ****************************************************************
    assign cpol = clock_idle_level_bit[sel_r];
    assign cpha = clock_phase_bit[sel_r];
    assign dd   = select_to_data_delay[sel_r*sme_pkg::DD_W +: sme_pkg::DD_W];

    // Commands during a frame are dropped; the host must not issue them
    assign start = cmd_wr && (state_r == sme_pkg::ST_IDLE)
                   && (cmd_code == sme_pkg::CMD_READ || cmd_code == sme_pkg::CMD_WRITE);
    assign leave_load     = (state_r == sme_pkg::ST_LOAD)
                            && (code_r != sme_pkg::CMD_WRITE || fifo_out_valid);
    assign fifo_out_ready = leave_load && (code_r == sme_pkg::CMD_WRITE);
    // Phase 0 samples on even edges, phase 1 on odd edges
    assign sample    = tick && (state_r == sme_pkg::ST_SHIFT) && (edge_r[0] == cpha);
    assign char_end  = tick && (state_r == sme_pkg::ST_SHIFT) && (edge_r == {len_r, 1'b1});
    assign frame_end = char_end && (left_r == '0);
    assign rx_in     = loopback_en ? tx_r : miso_s2_r;

    // ****************************************************************
    // Submodules
    // ****************************************************************
    sme_clk_div #(
        .WIDTH (sme_pkg::DIV_W)
    ) u_div (
        .core_clk (core_clk),
        .rst      (rst),
        .run      (periph_clk_run),
        .restart  (leave_load),
        .div      (clk_div),
        .tick     (tick)
    );

    sme_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_D)
    ) u_tx_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   (tx_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // ****************************************************************
    // Receive pin synchroniser
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            miso_s1_r <= 1'b0;
            miso_s2_r <= 1'b0;
        end else begin
            miso_s1_r <= miso_in;
            miso_s2_r <= miso_s1_r;
        end
    end

    // ****************************************************************
    // Frame sequencer
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= sme_pkg::ST_IDLE;
            sel_r   <= '0;
            len_r   <= '0;
            code_r  <= '0;
            left_r  <= '0;
            first_r <= 1'b0;
            lead_r  <= '0;
        end else begin
            unique case (state_r)
                sme_pkg::ST_IDLE: begin
                    if (start) begin
                        sel_r   <= select_number_field;
                        len_r   <= char_length_field;
                        code_r  <= cmd_code;
                        left_r  <= frame_length_field;
                        first_r <= 1'b1;
                        state_r <= sme_pkg::ST_LOAD;
                    end
                end
                sme_pkg::ST_LOAD: begin
                    lead_r <= '0;
                    if (leave_load) begin
                        state_r <= (first_r && dd != '0) ? sme_pkg::ST_LEAD : sme_pkg::ST_SHIFT;
                    end
                end
                sme_pkg::ST_LEAD: begin
                    // Two half periods per extra delay cycle
                    if (tick) begin
                        lead_r <= lead_r + 3'h1;
                        if (lead_r == {dd, 1'b0} - 3'h1) begin
                            state_r <= sme_pkg::ST_SHIFT;
                        end
                    end
                end
                sme_pkg::ST_SHIFT: begin
                    if (char_end) begin
                        first_r <= 1'b0;
                        left_r  <= left_r - 1'b1;
                        state_r <= frame_end ? sme_pkg::ST_IDLE : sme_pkg::ST_LOAD;
                    end
                end
                default: begin
                    state_r <= sme_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Serial clock and shift register
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (rst || state_r != sme_pkg::ST_SHIFT) begin
            edge_r <= '0;
            sclk_r <= 1'b0;
        end else if (tick) begin
            edge_r <= edge_r + 1'b1;
            sclk_r <= ~sclk_r;
        end
    end

    always_comb begin
        shreg_nxt = shreg_r;
        if (fifo_out_ready) begin
            shreg_nxt = fifo_out_data;
        end else if (leave_load) begin
            shreg_nxt = sme_pkg::RST_DATA;
        end else if (sample) begin
            shreg_nxt = {shreg_r[sme_pkg::DATA_W-2:0], rx_in};
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            shreg_r <= sme_pkg::RST_DATA;
            tx_r    <= 1'b0;
        end else begin
            shreg_r <= shreg_nxt;
            if (leave_load) begin
                tx_r <= shreg_nxt[sme_pkg::DATA_W-1];
            end else if (tick && state_r == sme_pkg::ST_SHIFT && !sample) begin
                tx_r <= shreg_r[sme_pkg::DATA_W-1];
            end
        end
    end

    // ****************************************************************
    // Selects and pins
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sel_act_r <= sme_pkg::RST_SEL;
        end else if (start) begin
            sel_act_r <= sme_pkg::NUM_SEL'(1) << select_number_field;
        end else if (frame_end) begin
            sel_act_r <= sme_pkg::RST_SEL;
        end
    end

    assign slave_select_out = ~(sel_act_r ^ select_polarity_bit);
    assign sclk_out         = sclk_r ^ cpol;
    assign mosi_out         = tx_r;
    assign busy             = (state_r == sme_pkg::ST_SHIFT) || (state_r == sme_pkg::ST_LEAD);

    // ****************************************************************
    // Status, count, receive word and interrupts
    // ****************************************************************
    // A completion in the same cycle as a clear keeps the flag set
    always_ff @(posedge core_clk) begin
        if (rst) begin
            char_done_flag  <= sme_pkg::RST_FLAG;
            frame_done_flag <= sme_pkg::RST_FLAG;
        end else begin
            if (char_end) begin
                char_done_flag <= 1'b1;
            end else if (status_rd || start) begin
                char_done_flag <= 1'b0;
            end
            if (frame_end) begin
                frame_done_flag <= 1'b1;
            end else if (status_rd || start) begin
                frame_done_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            char_count_field <= sme_pkg::RST_COUNT;
        end else if (char_end) begin
            char_count_field <= char_count_field + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_data   <= sme_pkg::RST_DATA;
            rx_valid  <= 1'b0;
            char_irq  <= 1'b0;
            frame_irq <= 1'b0;
        end else begin
            rx_valid  <= char_end;
            char_irq  <= char_end && char_irq_en;
            frame_irq <= frame_end && frame_irq_en;
            if (char_end) begin
                rx_data <= shreg_nxt;
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    int          lead_cyc;
    int          div_int;
    logic [5:0]  samp_cnt;

    assign div_int = (clk_div < sme_pkg::MIN_DIV) ? int'(sme_pkg::MIN_DIV) : int'(clk_div);

    always_ff @(posedge core_clk) begin
        if (rst || (leave_load && first_r)) begin
            lead_cyc <= 1;
        end else if (periph_clk_run) begin
            // Gated cycles do not move the divider, so they do not count toward the lead time
            lead_cyc <= lead_cyc + 1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || leave_load) begin
            samp_cnt <= '0;
        end else if (sample) begin
            samp_cnt <= samp_cnt + 6'h1;
        end
    end

    a_sel_onehot:
        assert property (@(posedge core_clk) disable iff (rst) $onehot0(sel_act_r))
        else $error("more than one slave select active");

    a_lead_delay:
        assert property (@(posedge core_clk) disable iff (rst)
            (tick && state_r == sme_pkg::ST_SHIFT && first_r && edge_r == '0 && periph_clk_run)
            |-> lead_cyc == (2 * int'(dd) + 1) * (div_int + 1))
        else $error("first serial edge at wrong time");

    a_bits_per_char:
        assert property (@(posedge core_clk) disable iff (rst)
            char_end |-> (samp_cnt + (sample ? 6'h1 : 6'h0)) == {1'b0, len_r} + 6'h1)
        else $error("sample count differs from character length");

    a_count_incr:
        assert property (@(posedge core_clk) disable iff (rst)
            char_end |=> char_count_field == $past(char_count_field) + 1'b1)
        else $error("character count did not advance");

    a_frame_flag:
        assert property (@(posedge core_clk) disable iff (rst)
            frame_end |=> frame_done_flag && !busy && sel_act_r == '0)
        else $error("frame end not flagged");

    a_flag_clear:
        assert property (@(posedge core_clk) disable iff (rst)
            (status_rd && !frame_end) |=> !frame_done_flag)
        else $error("frame flag not cleared by status read");

    a_sclk_rate:
        assert property (@(posedge core_clk) disable iff (rst)
            (sclk_r != $past(sclk_r)) |=> sclk_r == $past(sclk_r))
        else $error("serial clock faster than a quarter of the clock");

    a_shift_left:
        assert property (@(posedge core_clk) disable iff (rst)
            sample |=> shreg_r == {$past(shreg_r[sme_pkg::DATA_W-2:0]), $past(rx_in)})
        else $error("shift register did not shift left");

    a_loop_route:
        assert property (@(posedge core_clk) disable iff (rst)
            (sample && loopback_en) |=> shreg_r[0] == $past(tx_r))
        else $error("loopback bit not taken from transmit");

    a_idle_level:
        assert property (@(posedge core_clk) disable iff (rst)
            (state_r == sme_pkg::ST_IDLE) |-> (sclk_out == cpol) && !busy)
        else $error("serial clock not at idle level");
endmodule : sme_top
`default_nettype wire

/* File: testbench/sme_slave_model.sv */
`default_nettype none
module sme_slave_model (
    input  wire logic       core_clk,
    input  wire logic [3:0] slave_select_out,
    input  wire logic [3:0] select_polarity_bit,
    output logic            miso_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // Slave that answers with ones
    // ********
    logic flip_r = 1'b0;
    // A deselected line wanders so a stale level is never taken for data
    always @(posedge core_clk) flip_r <= ~flip_r;
    assign miso_in = |(~(slave_select_out ^ select_polarity_bit)) ? 1'b1 : flip_r;
endmodule : sme_slave_model
`default_nettype wire

/* File: testbench/sme_top_bench.sv */
`default_nettype none
module sme_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // Stimulus and checks
    // ********
    logic core_clk = 1'b0, rst = 1'b1, periph_clk_run = 1'b1, cmd_wr = 1'b0, loopback_en = 1'b1;
    logic char_irq_en = 1'b1, frame_irq_en = 1'b1, status_rd = 1'b0, tx_valid = 1'b0;
    logic [1:0]  select_number_field = 2'h0, cmd_code = 2'h0;
    logic [4:0]  char_length_field = 5'h0;
    logic [11:0] frame_length_field = 12'h0;
    logic [7:0]  clk_div = 8'h1, select_to_data_delay = 8'h0;
    logic [3:0]  select_polarity_bit = 4'h0, clock_idle_level_bit = 4'h0, clock_phase_bit = 4'h0;
    logic [31:0] tx_data = 32'h0;
    logic tx_ready, rx_valid, busy, char_done_flag, frame_done_flag, char_irq, frame_irq, sclk_out, mosi_out, miso_in;
    logic [31:0] rx_data;
    logic [15:0] char_count_field;
    logic [3:0]  slave_select_out;
    logic [15:0] cnt_exp = 16'h0;
    logic [31:0] words[$];
    int error_cnt = 0, samples_checked = 0, cycles = 0, tog = 0, firq = 0, bsy = 0;

    sme_top uut (.core_clk, .rst, .periph_clk_run, .cmd_wr, .select_number_field, .char_length_field,
        .cmd_code, .frame_length_field, .clk_div, .select_polarity_bit, .clock_idle_level_bit,
        .clock_phase_bit, .select_to_data_delay, .loopback_en, .char_irq_en, .frame_irq_en, .status_rd,
        .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_data, .busy, .char_done_flag, .frame_done_flag,
        .char_count_field, .char_irq, .frame_irq, .sclk_out, .mosi_out, .miso_in, .slave_select_out);
    sme_slave_model far (.core_clk, .slave_select_out, .select_polarity_bit, .miso_in);

    always #5 core_clk = ~core_clk;
    // Edges are counted as they happen, so a character's last one is in before its check
    always @(sclk_out) tog++;
    always @(posedge core_clk) begin
        cycles++;
        if (busy === 1'b1) bsy++;
        if (frame_irq === 1'b1) firq++;
        if (cycles == 60000) begin
            error_cnt++;
            final_report();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("mismatches %0d, comparisons %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report

    function automatic logic [31:0] low_bits(input logic [31:0] w, input int len);
        return (len == 32) ? w : (w & ((32'h1 << len) - 32'h1));
    endfunction : low_bits

    task automatic run_frame(input logic [1:0] code, input logic [1:0] s, input int len, input int n);
        logic [3:0]  idle;
        logic [31:0] w;
        int          k;
        int          f0;
        idle = ~select_polarity_bit;
        for (int i = 0; i < n && code == sme_pkg::CMD_WRITE; i++) begin
            w = $urandom();
            words.push_back(w);
            @(negedge core_clk);
            tx_valid = 1'b1;
            tx_data = w;
            @(negedge core_clk);
            tx_valid = 1'b0;
        end
        if (code == sme_pkg::CMD_WRITE) check("tx_ready", tx_ready, n < 8);
        f0 = firq;
        select_number_field = s;
        char_length_field = 5'(len - 1);
        frame_length_field = 12'(n - 1);
        cmd_code = code;
        loopback_en = (code == sme_pkg::CMD_WRITE);
        cmd_wr = 1'b1;
        @(negedge core_clk);
        cmd_wr = 1'b0;
        check("frame_done_flag", frame_done_flag, 1'b0);
        check("slave_select_out", slave_select_out, idle ^ (4'h1 << s));
        // Idle level may move with the new slave; only count toggles after that
        @(negedge core_clk);
        tog = 0;
        bsy = 0;
        // One read frame gates the port clock longer than any lead time; nothing may move meanwhile
        if (code == sme_pkg::CMD_READ && s == 2'h1) begin
            periph_clk_run = 1'b0;
            repeat (40) @(negedge core_clk);
            check("sclk while gated", tog, 0);
            check("rx_valid while gated", rx_valid, 1'b0);
            periph_clk_run = 1'b1;
        end
        for (int c = 0; c < n; c++) begin
            for (k = 0; k < 600 && rx_valid !== 1'b1; k++) @(negedge core_clk);
            check("rx_valid", rx_valid, 1'b1);
            cnt_exp++;
            w = (code == sme_pkg::CMD_WRITE) ? words.pop_front() >> (32 - len) : low_bits(32'hffffffff, len);
            check("rx_data", low_bits(rx_data, len), w);
            check("sclk toggles", tog, 2 * len);
            check("char_count_field", char_count_field, cnt_exp);
            check("busy", busy, 1'b0);
            check("busy seen", bsy >= 2 * len, 1'b1);
            check("char_irq", char_irq, char_irq_en);
            check("char_done_flag", char_done_flag, 1'b1);
            if (c < n - 1) check("select held", slave_select_out, idle ^ (4'h1 << s));
            if (code == sme_pkg::CMD_READ) check("mosi_out", mosi_out, 1'b0);
            tog = 0;
            bsy = 0;
            @(negedge core_clk);
        end
        @(negedge core_clk);
        check("frame_done_flag", frame_done_flag, 1'b1);
        check("frame_irq", firq - f0, frame_irq_en);
        check("slave_select_out", slave_select_out, idle);
        check("sclk idle", sclk_out, clock_idle_level_bit[s]);
        if (n % 2 == 1) begin
            status_rd = 1'b1;
            @(negedge core_clk);
            status_rd = 1'b0;
            @(negedge core_clk);
            check("frame_done_flag", frame_done_flag, 1'b0);
            check("char_done_flag", char_done_flag, 1'b0);
        end
    endtask : run_frame

    initial begin
        logic [1:0] m;
        int         len;
        int         n;
        void'($urandom(64));
        repeat (5) @(negedge core_clk);
        check("slave_select_out", slave_select_out, 4'hf);
        check("char_count_field", char_count_field, 16'h0);
        check("sclk_out", sclk_out, 1'b0);
        check("busy", busy, 1'b0);
        rst = 1'b0;
        for (int i = 0; i < 16; i++) begin
            m = 2'(i / 4);
            clock_idle_level_bit[i % 4] = m[1];
            clock_phase_bit[i % 4] = m[0];
            select_polarity_bit = 4'($urandom());
            select_to_data_delay = 8'($urandom());
            clk_div = 8'($urandom_range(3));
            char_irq_en = (i % 5 != 4);
            frame_irq_en = (i % 7 != 6);
            len = (i == 0) ? 1 : (i == 1) ? 32 : $urandom_range(32, 1);
            n = (i == 3) ? 8 : $urandom_range(4, 1);
            // Each frame ends before the next command, whatever slave it names
            run_frame((i % 3 == 2) ? sme_pkg::CMD_READ : sme_pkg::CMD_WRITE, 2'(i % 4), len, n);
        end
        final_report();
    end
endmodule : sme_top_bench
`default_nettype wire
